// ### common/fpfc_consts.vh
// constants for the four-pair fault policy register block
`ifndef FPFC_CONSTS_VH
`define FPFC_CONSTS_VH

// ----------------------------------------
// command codes
// ----------------------------------------
`define FPFC_CMD_TEMP 8'h2C
`define FPFC_CMD_POLICY 8'h2D
`define FPFC_POLICY_RESET 8'h00
`define FPFC_TEMP_RESET 8'h00

// ----------------------------------------
// policy field positions
// ----------------------------------------
`define FPFC_BIT_ILIM34 7
`define FPFC_BIT_ILIM12 6
`define FPFC_BIT_PCUT34 5
`define FPFC_BIT_PCUT12 4
`define FPFC_BIT_SUM34 3
`define FPFC_BIT_SUM12 2
`define FPFC_BIT_DISC34 1
`define FPFC_BIT_DISC12 0

// ----------------------------------------
// temperature refresh timing
// ----------------------------------------
`define FPFC_CLK_HZ 10000000
`define FPFC_TEMP_PERIOD_MS 1000
`define FPFC_TEMP_CYCLES ((`FPFC_CLK_HZ / 1000) * `FPFC_TEMP_PERIOD_MS)
`define FPFC_TDIV_W 24
`define FPFC_ONE_TDIV 24'h000001
`define FPFC_ZERO_TDIV 24'h000000
// last divider count of the one second period, sized to the divider
`define FPFC_TEMP_LAST 24'h98967F

`endif

// ### logic/fpfc_port_gate.v
// per-port fault shutdown decision for one 4-pair port (two channels)
`timescale 1ns/1ps
`default_nettype none

module fpfc_port_gate (
	input wire clk,
	input wire srst,
	input wire current_limit_fault_gang,
	input wire pcut_gang,
	input wire summed_en,
	input wire current_limit_fault_a,
	input wire current_limit_fault_b,
	input wire pcut_a,
	input wire pcut_b,
	input wire sum_pcut,
	output reg off_a,
	output reg off_b
);

	// ----------------------------------------
	// registered channel-off decision
	// ----------------------------------------
	// gang bits widen a single-channel fault to the whole port
	always @(posedge clk) begin
		if (srst) begin
			off_a <= 1'b0;
			off_b <= 1'b0;
		end else begin
			off_a <= current_limit_fault_a | (current_limit_fault_gang & current_limit_fault_b) | pcut_a | (pcut_gang & pcut_b) | (summed_en & sum_pcut);
			off_b <= current_limit_fault_b | (current_limit_fault_gang & current_limit_fault_a) | pcut_b | (pcut_gang & pcut_a) | (summed_en & sum_pcut);
		end
	end

endmodule

`default_nettype wire

// ### logic/fpfc_top.v
// four-pair fault policy register, shutdown steering and die temperature code
`timescale 1ns/1ps
`default_nettype none
`include "fpfc_consts.vh"

// Behaviour
// - code times step, minus twenty, gives temperature
// - code refreshed about once per second
// - policy register command 2Dh, read and write
// - current_limit_fault gang one: both channels off
// - current_limit_fault gang zero: only faulted channel off
// - pcut gang selects both or single channel off
// - auto mode sets gang bits after turn-on
// - all policy bits reset to zero
// - summed enable gates summed policing only
// - disconnect select: one 4.5mA, zero 6.5mA
module fpfc_top (
	input wire CLOCK_I,
	input wire SRST_I,
	input wire CMD_WR_I,
	input wire CMD_RD_I,
	input wire [7:0] CMD_CODE_I,
	input wire [7:0] CMD_WDATA_I,
	output reg [7:0] CMD_RDATA_O,
	output reg CMD_RVALID_O,
	input wire AUTO_MODE_I,
	input wire [1:0] TURN_ON_4P_SS_I,
	input wire [1:0] CH12_CURRENT_LIMIT_FAULT_I,
	input wire [1:0] CH34_CURRENT_LIMIT_FAULT_I,
	input wire [1:0] CH12_PCUT_I,
	input wire [1:0] CH34_PCUT_I,
	input wire [1:0] SUM_PCUT_I,
	input wire [7:0] TEMP_SAMPLE_I,
	output wire [1:0] CH12_OFF_O,
	output wire [1:0] CH34_OFF_O,
	output reg [1:0] SUMMED_POLICING_ON_O,
	output reg [1:0] DISCONNECT_LOW_SEL_O
);

	reg [7:0] four_pair_fault_policy;
	reg [7:0] die_temperature_code;
	reg [`FPFC_TDIV_W-1:0] tdiv;
	reg [1:0] turn_on_q1;
	reg [1:0] turn_on_q2;
	reg [1:0] turn_on_q3;
	reg [7:0] temp_q1;
	reg [7:0] temp_q2;
	reg [1:0] ilim12_q1, ilim12_q2, ilim34_q1, ilim34_q2;
	reg [1:0] pcut12_q1, pcut12_q2, pcut34_q1, pcut34_q2;
	reg [1:0] sum_q1, sum_q2;
	reg auto_q1, auto_q2;
	wire [1:0] turn_on_rise;
	wire temp_tick;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// every fault, mode and sample pin gets two flops (command port pins get none), turn-on a third for its edge; first stage feeds only the second
	always @(posedge CLOCK_I) begin
		if (SRST_I) begin
			turn_on_q1 <= 2'h0;
			turn_on_q2 <= 2'h0;
			turn_on_q3 <= 2'h0;
			temp_q1 <= 8'h00;
			temp_q2 <= 8'h00;
			ilim12_q1 <= 2'h0;
			ilim12_q2 <= 2'h0;
			ilim34_q1 <= 2'h0;
			ilim34_q2 <= 2'h0;
			pcut12_q1 <= 2'h0;
			pcut12_q2 <= 2'h0;
			pcut34_q1 <= 2'h0;
			pcut34_q2 <= 2'h0;
			sum_q1 <= 2'h0;
			sum_q2 <= 2'h0;
			auto_q1 <= 1'b0;
			auto_q2 <= 1'b0;
		end else begin
			turn_on_q1 <= TURN_ON_4P_SS_I;
			turn_on_q2 <= turn_on_q1;
			turn_on_q3 <= turn_on_q2;
			temp_q1 <= TEMP_SAMPLE_I;
			temp_q2 <= temp_q1;
			ilim12_q1 <= CH12_CURRENT_LIMIT_FAULT_I;
			ilim12_q2 <= ilim12_q1;
			ilim34_q1 <= CH34_CURRENT_LIMIT_FAULT_I;
			ilim34_q2 <= ilim34_q1;
			pcut12_q1 <= CH12_PCUT_I;
			pcut12_q2 <= pcut12_q1;
			pcut34_q1 <= CH34_PCUT_I;
			pcut34_q2 <= pcut34_q1;
			sum_q1 <= SUM_PCUT_I;
			sum_q2 <= sum_q1;
			auto_q1 <= AUTO_MODE_I;
			auto_q2 <= auto_q1;
		end
	end

	// turn-on of a single-signature load seen as a rising edge
	assign turn_on_rise = turn_on_q2 & ~turn_on_q3;

	// ----------------------------------------
	// policy register
	// ----------------------------------------
	// auto setting lands on turn-on; a host write in the same cycle wins
	// since it is the later intent, and any later write overrides too
	always @(posedge CLOCK_I) begin
		if (SRST_I) begin
			four_pair_fault_policy <= `FPFC_POLICY_RESET;
		end else if (CMD_WR_I && CMD_CODE_I == `FPFC_CMD_POLICY) begin
			four_pair_fault_policy <= CMD_WDATA_I;
		end else if (auto_q2) begin
			if (turn_on_rise[0]) begin
				four_pair_fault_policy[`FPFC_BIT_ILIM12] <= 1'b1;
				four_pair_fault_policy[`FPFC_BIT_PCUT12] <= 1'b1;
			end
			if (turn_on_rise[1]) begin
				four_pair_fault_policy[`FPFC_BIT_ILIM34] <= 1'b1;
				four_pair_fault_policy[`FPFC_BIT_PCUT34] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// temperature refresh divider
	// ----------------------------------------
	// one-cycle tick once per second; between ticks the code holds steady
	assign temp_tick = (tdiv == `FPFC_TEMP_LAST);

	always @(posedge CLOCK_I) begin
		if (SRST_I) begin
			tdiv <= `FPFC_ZERO_TDIV;
			die_temperature_code <= `FPFC_TEMP_RESET;
		end else if (temp_tick) begin
			tdiv <= `FPFC_ZERO_TDIV;
			die_temperature_code <= temp_q2;
		end else begin
			tdiv <= tdiv + `FPFC_ONE_TDIV;
		end
	end

	// ----------------------------------------
	// command read port
	// ----------------------------------------
	// unknown codes answer zero so the host never sees stale data
	always @(posedge CLOCK_I) begin
		if (SRST_I) begin
			CMD_RDATA_O <= 8'h00;
			CMD_RVALID_O <= 1'b0;
		end else begin
			CMD_RVALID_O <= CMD_RD_I;
			if (CMD_RD_I) begin
				case (CMD_CODE_I)
					`FPFC_CMD_POLICY: CMD_RDATA_O <= four_pair_fault_policy;
					`FPFC_CMD_TEMP: CMD_RDATA_O <= die_temperature_code;
					default: CMD_RDATA_O <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// static policy outputs
	// ----------------------------------------
	always @(posedge CLOCK_I) begin
		if (SRST_I) begin
			SUMMED_POLICING_ON_O <= 2'h0;
			DISCONNECT_LOW_SEL_O <= 2'h0;
		end else begin
			SUMMED_POLICING_ON_O <= {four_pair_fault_policy[`FPFC_BIT_SUM34],
				four_pair_fault_policy[`FPFC_BIT_SUM12]};
			DISCONNECT_LOW_SEL_O <= {four_pair_fault_policy[`FPFC_BIT_DISC34],
				four_pair_fault_policy[`FPFC_BIT_DISC12]};
		end
	end

	// ----------------------------------------
	// per-port shutdown steering
	// ----------------------------------------
	fpfc_port_gate u_port12 (
		.clk(CLOCK_I),
		.srst(SRST_I),
		.current_limit_fault_gang(four_pair_fault_policy[`FPFC_BIT_ILIM12]),
		.pcut_gang(four_pair_fault_policy[`FPFC_BIT_PCUT12]),
		.summed_en(four_pair_fault_policy[`FPFC_BIT_SUM12]),
		.current_limit_fault_a(ilim12_q2[0]),
		.current_limit_fault_b(ilim12_q2[1]),
		.pcut_a(pcut12_q2[0]),
		.pcut_b(pcut12_q2[1]),
		.sum_pcut(sum_q2[0]),
		.off_a(CH12_OFF_O[0]),
		.off_b(CH12_OFF_O[1])
	);

	fpfc_port_gate u_port34 (
		.clk(CLOCK_I),
		.srst(SRST_I),
		.current_limit_fault_gang(four_pair_fault_policy[`FPFC_BIT_ILIM34]),
		.pcut_gang(four_pair_fault_policy[`FPFC_BIT_PCUT34]),
		.summed_en(four_pair_fault_policy[`FPFC_BIT_SUM34]),
		.current_limit_fault_a(ilim34_q2[0]),
		.current_limit_fault_b(ilim34_q2[1]),
		.pcut_a(pcut34_q2[0]),
		.pcut_b(pcut34_q2[1]),
		.sum_pcut(sum_q2[1]),
		.off_a(CH34_OFF_O[0]),
		.off_b(CH34_OFF_O[1])
	);

endmodule

`default_nettype wire

// ### verif/fpfc_host.sv
// host model for the one-byte command port
`timescale 1ns/1ps
`default_nettype none
module fpfc_host (
	input wire clk,
	input wire rvalid,
	input wire [7:0] rdata,
	output logic wr,
	output logic rd,
	output logic [7:0] code,
	output logic [7:0] wdata
);
	// idle strobes until the first command
	initial {wr, rd, code, wdata} = 18'h00000;
	// one code and one data byte, strobe held over one edge
	task automatic put(input logic [7:0] c, input logic [7:0] v);
		wr = 1'b1;
		code = c;
		wdata = v;
		@(posedge clk);
		#1 wr = 1'b0;
	endtask
	// answer is taken while it stands; one idle edge follows so reads never abut
	task automatic get(input logic [7:0] c, output logic [7:0] v, output logic ok);
		rd = 1'b1;
		code = c;
		@(posedge clk);
		#1 rd = 1'b0;
		v = rdata;
		ok = rvalid;
		@(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// ### verif/fpfc_top_sva.sv
// port checker for the fault policy block
`timescale 1ns/1ps
`default_nettype none
module fpfc_chk (
	input wire CLOCK_I,
	input wire SRST_I,
	input wire CMD_WR_I,
	input wire CMD_RD_I,
	input wire [7:0] CMD_CODE_I,
	input wire [7:0] CMD_WDATA_I,
	input wire [7:0] CMD_RDATA_O,
	input wire CMD_RVALID_O,
	input wire [1:0] CH12_CURRENT_LIMIT_FAULT_I,
	input wire [1:0] CH12_PCUT_I,
	input wire [1:0] SUM_PCUT_I,
	input wire [1:0] CH12_OFF_O,
	input wire [1:0] SUMMED_POLICING_ON_O,
	input wire [1:0] DISCONNECT_LOW_SEL_O
);
	// one clock; reset cancels attempts in flight
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SRST_I);
	a_read_answer: assert property (CMD_RD_I |=> CMD_RVALID_O) else $error("no answer");
	a_answer_once: assert property (!CMD_RD_I |=> !CMD_RVALID_O) else $error("stray answer");
	a_unmapped_zero: assert property (CMD_RD_I && CMD_CODE_I != 8'h2C && CMD_CODE_I != 8'h2D
		|=> CMD_RDATA_O == 8'h00) else $error("unmapped not zero");
	a_write_readback: assert property (CMD_WR_I && CMD_CODE_I == 8'h2D ##1 CMD_RD_I && CMD_CODE_I == 8'h2D
		|=> CMD_RDATA_O == $past(CMD_WDATA_I, 2)) else $error("readback differs");
	a_summed_follow: assert property (CMD_WR_I && CMD_CODE_I == 8'h2D
		|=> ##1 SUMMED_POLICING_ON_O == $past(CMD_WDATA_I[3:2], 2)) else $error("summed wrong");
	a_dcdt_follow: assert property (CMD_WR_I && CMD_CODE_I == 8'h2D
		|-> ##2 DISCONNECT_LOW_SEL_O == $past(CMD_WDATA_I[1:0], 2)) else $error("select wrong");
	a_current_limit_fault_own_off: assert property (CH12_CURRENT_LIMIT_FAULT_I[0] |-> ##3 CH12_OFF_O[0]) else $error("current_limit_fault on");
	a_pcut_own_off: assert property (CH12_PCUT_I[1] |-> ##3 CH12_OFF_O[1]) else $error("pcut on");
	a_quiet_stays_on: assert property (CH12_CURRENT_LIMIT_FAULT_I == 2'b00 && CH12_PCUT_I == 2'b00 && !SUM_PCUT_I[0]
		|-> ##3 CH12_OFF_O == 2'b00) else $error("off without fault");
endmodule
bind fpfc_top fpfc_chk u_chk (.CLOCK_I, .SRST_I, .CMD_WR_I, .CMD_RD_I, .CMD_CODE_I, .CMD_WDATA_I,
	.CMD_RDATA_O, .CMD_RVALID_O, .CH12_CURRENT_LIMIT_FAULT_I, .CH12_PCUT_I, .SUM_PCUT_I, .CH12_OFF_O,
	.SUMMED_POLICING_ON_O, .DISCONNECT_LOW_SEL_O);
`default_nettype wire

// ### verif/tb_top.sv
// bench for the four-pair fault policy block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, srst, am, wr, rd, rv, ok;
	logic [7:0] code, wd, rdat, d;
	logic [1:0] ton, i12, i34, p12, p34, sp, o12, o34, se, ds;
	logic [35:0] r;
	int err_total = 0;
	int n_checks = 0;
	// ---
	// rows: policy, faults i12 p12 i34 p34 sum, expected off12 off34
	// ---
	logic [35:0] rows [8] = '{36'h00_1000010, 36'hC0_1020033, 36'h30_0201033, 36'h09_0200020,
		36'h0C_0000333, 36'h00_0000300, 36'h40_0010001, 36'h03_0000000};
	fpfc_top i_dut (.CLOCK_I(clk), .SRST_I(srst), .CMD_WR_I(wr), .CMD_RD_I(rd), .CMD_CODE_I(code),
		.CMD_WDATA_I(wd), .CMD_RDATA_O(rdat), .CMD_RVALID_O(rv), .AUTO_MODE_I(am), .TURN_ON_4P_SS_I(ton),
		.CH12_CURRENT_LIMIT_FAULT_I(i12), .CH34_CURRENT_LIMIT_FAULT_I(i34), .CH12_PCUT_I(p12), .CH34_PCUT_I(p34), .SUM_PCUT_I(sp),
		.TEMP_SAMPLE_I(8'h5A), .CH12_OFF_O(o12), .CH34_OFF_O(o34), .SUMMED_POLICING_ON_O(se),
		.DISCONNECT_LOW_SEL_O(ds));
	fpfc_host i_host (.clk, .rvalid(rv), .rdata(rdat), .wr, .rd, .code, .wdata(wd));
	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	// a missing answer ends the run at once
	task automatic rdchk(input string nm, input logic [7:0] c, input logic [7:0] exp);
		i_host.get(c, d, ok);
		chk({nm, " valid"}, {7'h00, ok}, 8'h01);
		if (ok !== 1'b1) tally_and_finish();
		else chk(nm, d, exp);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		srst = 1'b1;
		am = 1'b0;
		{ton, i12, i34, p12, p34, sp} = 12'h000;
		repeat (20) @(posedge clk);
		#1 srst = 1'b0;
		rdchk("policy", 8'h2D, 8'h00);
		rdchk("temp", 8'h2C, 8'h00);
		rdchk("unmapped", 8'h2E, 8'h00);
		i_host.put(8'h2C, 8'hFF);
		rdchk("policy", 8'h2D, 8'h00);
		rdchk("temp ro", 8'h2C, 8'h00);
		chk("off", {4'h0, o12, o34}, 8'h00);
		$display("reset test done");
		foreach (rows[i]) begin
			r = rows[i];
			i_host.put(8'h2D, r[35:28]);
			rdchk("policy", 8'h2D, r[35:28]);
			chk("summed", {6'h00, se}, {6'h00, r[31:30]});
			chk("dcdt", {6'h00, ds}, {6'h00, r[29:28]});
			{i12, p12, i34, p34, sp} = {r[25:24], r[21:20], r[17:16], r[13:12], r[9:8]};
			repeat (4) @(posedge clk);
			#1 chk("off", {4'h0, o12, o34}, {4'h0, r[5:4], r[1:0]});
			{i12, p12, i34, p34, sp} = 10'h000;
			repeat (4) @(posedge clk);
			#1 $display("row %0d done", i);
		end
		// turn-on outside auto mode leaves the gang bits alone
		ton = 2'b01;
		repeat (6) @(posedge clk);
		#1 rdchk("manual", 8'h2D, 8'h03);
		ton = 2'b00;
		// auto setting, then host override
		am = 1'b1;
		i_host.put(8'h2D, 8'h00);
		ton = 2'b01;
		repeat (6) @(posedge clk);
		#1 rdchk("auto12", 8'h2D, 8'h50);
		i_host.put(8'h2D, 8'h00);
		rdchk("override", 8'h2D, 8'h00);
		ton = 2'b11;
		repeat (6) @(posedge clk);
		#1 rdchk("auto34", 8'h2D, 8'hA0);
		ton = 2'b10;
		repeat (6) @(posedge clk);
		#1 ton = 2'b11;
		repeat (6) @(posedge clk);
		#1 rdchk("again", 8'h2D, 8'hF0);
		$display("auto test done");
		i_host.put(8'h2D, 8'hFF);
		repeat (2) @(posedge clk);
		#1 chk("summed", {6'h00, se}, 8'h03);
		am = 1'b0;
		ton = 2'b00;
		srst = 1'b1;
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		rdchk("policy", 8'h2D, 8'h00);
		chk("summed", {6'h00, se}, 8'h00);
		chk("dsel", {6'h00, ds}, 8'h00);
		$display("second reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
